// file: hdl/flash_seq_map.vh
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH

// register byte offsets
`define OFS_ADDR_HIGH 8'h00
`define OFS_ADDR_LOW 8'h04
`define OFS_DATA_LOW 8'h08
`define OFS_DATA_HIGH 8'h0c
`define OFS_FLASH_CONTROL 8'h10
`define OFS_UNLOCK_KEY 8'h14

// flash_control_reg bit positions
`define BIT_READ_TRIGGER 0
`define BIT_WRITE_TRIGGER 1
`define BIT_WRITE_ENABLE 2
`define BIT_WRITE_ABORT 3
`define BIT_ROW_ERASE 4
`define BIT_LATCH_ONLY 5
`define BIT_CONFIG_SPACE 6

// unlock keys and blank value
`define UNLOCK_KEY_FIRST 8'h55
`define UNLOCK_KEY_SECOND 8'haa
`define LATCH_BLANK 14'h3fff

// reset values
`define RST_ADDR 15'h0000
`define RST_DATA 14'h0000
`define RST_HRDATA 32'h0000_0000

// erase and program time
`define OP_TIME_US 2000
`define CLK_MHZ 20
`define OP_CYCLES_DEFAULT (`OP_TIME_US * `CLK_MHZ)

`endif

// file: hdl/flash_self_program_sequencer.v
`timescale 1ns/1ps
`include "flash_seq_map.vh"
// Overview of operation
// - flash read happens in second cycle after trigger; that slot is forced idle
// - read word lands in data pair next cycle and holds until read or write
// - erase, latch load and program need a complete unbroken unlock sequence
// - a broken unlock sequence starts no latch load or programming
// - setting write trigger forces two idle instruction slots
// - erase or program stalls the core for the operation time, 2 ms
// - clocks keep running while stalled; execution resumes at third instruction
// - latch-only loads force two idle slots then continue without stall
// - row erase uses the row holding the loaded address, whole rows only
// - programming never erases anything by itself
// - one program operation writes at most the 32 row latches
// - upper 10 address bits pick the row, lower 5 pick the latch
// - all latches return to 0x3fff after any program or erase completes
// - with latch-only set, an unlocked write only loads the addressed latch
// - with latch-only clear, it loads the last word then programs the row
// - triggers can only be set by software; hardware clears them when done
// - a core reset during a write sets the write abort flag
// - unlock key register is write-only and reads as zero
// - address pair holds 15-bit word address, data pair one 14-bit word
module flash_self_program_sequencer #(
	parameter LATCHES = 32,
	parameter LATCH_BITS = 5,
	parameter ADDR_W = 15,
	parameter DATA_W = 14,
	parameter OP_CYCLES = `OP_CYCLES_DEFAULT,
	parameter CNT_W = 16
) (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_n_i,
	// warm reset of the core, synchronous
	input wire core_reset_i,
	// ahb-lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output wire [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	// flash array
	output wire [ADDR_W-1:0] flash_addr_o,
	output wire flash_rd_o,
	input wire [DATA_W-1:0] flash_rdata_i,
	output wire flash_erase_o,
	output wire flash_prog_o,
	output wire [LATCHES*DATA_W-1:0] flash_row_data_o,
	// core instruction stream
	output wire cpu_nop_force_o,
	output wire cpu_stall_o
);

localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_RD1 = 3'd1;
localparam [2:0] ST_RD2 = 3'd2;
localparam [2:0] ST_WN1 = 3'd3;
localparam [2:0] ST_WN2 = 3'd4;
localparam [2:0] ST_BUSY = 3'd5;
localparam integer OP_LAST_INT = OP_CYCLES - 1;
localparam [CNT_W-1:0] OP_LAST = OP_LAST_INT[CNT_W-1:0];

reg [2:0] state_reg;
reg [ADDR_W-1:0] addr_reg;
reg [DATA_W-1:0] data_reg;
reg read_trigger_reg;
reg write_trigger_reg;
reg write_enable_reg;
reg write_abort_reg;
reg row_erase_reg;
reg latch_only_reg;
reg config_space_reg;
reg [1:0] unlock_step_reg;
reg op_erase_reg;
reg op_prog_reg;
reg [ADDR_W-1:0] op_addr_reg;
reg [CNT_W-1:0] cnt_reg;
reg load_req_reg;
reg blank_req_reg;
reg nop_reg;
reg stall_reg;
reg flash_rd_reg;
reg flash_erase_reg;
reg flash_prog_reg;
reg [31:0] hrdata_reg;
reg hreadyout_reg;
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
reg [31:0] rd_mux;
reg [DATA_W-1:0] latch_reg [0:LATCHES-1];

wire bus_take = hsel_i & htrans_i[1] & hready_i;
wire [7:0] ctrl_value = {1'b0, config_space_reg, latch_only_reg, row_erase_reg, write_abort_reg,
	write_enable_reg, write_trigger_reg, read_trigger_reg};
wire write_start = hwdata_i[`BIT_WRITE_TRIGGER] & (state_reg == ST_IDLE) & (unlock_step_reg == 2'd2)
	& hwdata_i[`BIT_WRITE_ENABLE] & ~hwdata_i[`BIT_CONFIG_SPACE];
wire read_start = hwdata_i[`BIT_READ_TRIGGER] & (state_reg == ST_IDLE);

assign hrdata_o = hrdata_reg;
assign hreadyout_o = hreadyout_reg;
assign hresp_o = 1'b0;
assign flash_addr_o = op_addr_reg;
assign flash_rd_o = flash_rd_reg;
assign flash_erase_o = flash_erase_reg;
assign flash_prog_o = flash_prog_reg;
assign cpu_nop_force_o = nop_reg;
assign cpu_stall_o = stall_reg;

// register read view
always @* begin
	rd_mux = 32'h0000_0000;
	case (haddr_i[7:0])
	`OFS_ADDR_HIGH: rd_mux = {25'h0000000, addr_reg[ADDR_W-1:8]};
	`OFS_ADDR_LOW: rd_mux = {24'h000000, addr_reg[7:0]};
	`OFS_DATA_LOW: rd_mux = {24'h000000, data_reg[7:0]};
	`OFS_DATA_HIGH: rd_mux = {26'h0000000, data_reg[DATA_W-1:8]};
	`OFS_FLASH_CONTROL: rd_mux = {24'h000000, ctrl_value};
	`OFS_UNLOCK_KEY: rd_mux = 32'h0000_0000;
	default: rd_mux = 32'h0000_0000;
	endcase
end

// write latches, one per word of the row
genvar gi;
generate
	for (gi = 0; gi < LATCHES; gi = gi + 1) begin : g_latch
		always @(posedge sys_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				latch_reg[gi] <= `LATCH_BLANK;
			end else if (blank_req_reg) begin
				latch_reg[gi] <= `LATCH_BLANK;
			end else if (load_req_reg && {{(32-LATCH_BITS){1'b0}}, op_addr_reg[LATCH_BITS-1:0]} == gi) begin
				latch_reg[gi] <= data_reg;
			end
		end
		assign flash_row_data_o[gi*DATA_W +: DATA_W] = latch_reg[gi];
	end
endgenerate

always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		state_reg <= ST_IDLE;
		addr_reg <= `RST_ADDR;
		data_reg <= `RST_DATA;
		read_trigger_reg <= 1'b0;
		write_trigger_reg <= 1'b0;
		write_enable_reg <= 1'b0;
		write_abort_reg <= 1'b0;
		row_erase_reg <= 1'b0;
		latch_only_reg <= 1'b0;
		config_space_reg <= 1'b0;
		unlock_step_reg <= 2'd0;
		op_erase_reg <= 1'b0;
		op_prog_reg <= 1'b0;
		op_addr_reg <= `RST_ADDR;
		cnt_reg <= {CNT_W{1'b0}};
		load_req_reg <= 1'b0;
		blank_req_reg <= 1'b0;
		nop_reg <= 1'b0;
		stall_reg <= 1'b0;
		flash_rd_reg <= 1'b0;
		flash_erase_reg <= 1'b0;
		flash_prog_reg <= 1'b0;
		hrdata_reg <= `RST_HRDATA;
		hreadyout_reg <= 1'b1;
		wr_pend_reg <= 1'b0;
		wr_addr_reg <= 8'h00;
	end else if (core_reset_i) begin
		if (write_trigger_reg)
			write_abort_reg <= 1'b1;
		state_reg <= ST_IDLE;
		read_trigger_reg <= 1'b0;
		write_trigger_reg <= 1'b0;
		write_enable_reg <= 1'b0;
		unlock_step_reg <= 2'd0;
		op_erase_reg <= 1'b0;
		op_prog_reg <= 1'b0;
		cnt_reg <= {CNT_W{1'b0}};
		load_req_reg <= 1'b0;
		blank_req_reg <= 1'b1;
		nop_reg <= 1'b0;
		stall_reg <= 1'b0;
		flash_rd_reg <= 1'b0;
		flash_erase_reg <= 1'b0;
		flash_prog_reg <= 1'b0;
		hreadyout_reg <= 1'b1;
		wr_pend_reg <= 1'b0;
	end else begin
		load_req_reg <= 1'b0;
		blank_req_reg <= 1'b0;
		if (state_reg == ST_IDLE)
			op_addr_reg <= addr_reg;
		// address phase: reads answer at once, writes take one wait state
		if (bus_take) begin
			if (hwrite_i) begin
				wr_pend_reg <= 1'b1;
				wr_addr_reg <= haddr_i[7:0];
				hreadyout_reg <= 1'b0;
			end else begin
				hrdata_reg <= rd_mux;
			end
		end
		// data phase of a write
		if (wr_pend_reg) begin
			wr_pend_reg <= 1'b0;
			hreadyout_reg <= 1'b1;
			if (wr_addr_reg != `OFS_UNLOCK_KEY)
				unlock_step_reg <= 2'd0;
			case (wr_addr_reg)
			`OFS_ADDR_HIGH: addr_reg[ADDR_W-1:8] <= hwdata_i[ADDR_W-9:0];
			`OFS_ADDR_LOW: addr_reg[7:0] <= hwdata_i[7:0];
			`OFS_DATA_LOW: data_reg[7:0] <= hwdata_i[7:0];
			`OFS_DATA_HIGH: data_reg[DATA_W-1:8] <= hwdata_i[DATA_W-9:0];
			`OFS_UNLOCK_KEY: begin
				if (hwdata_i[7:0] == `UNLOCK_KEY_FIRST)
					unlock_step_reg <= 2'd1;
				else if (hwdata_i[7:0] == `UNLOCK_KEY_SECOND && unlock_step_reg == 2'd1)
					unlock_step_reg <= 2'd2;
				else
					unlock_step_reg <= 2'd0;
			end
			`OFS_FLASH_CONTROL: begin
				write_enable_reg <= hwdata_i[`BIT_WRITE_ENABLE];
				row_erase_reg <= hwdata_i[`BIT_ROW_ERASE];
				latch_only_reg <= hwdata_i[`BIT_LATCH_ONLY];
				config_space_reg <= hwdata_i[`BIT_CONFIG_SPACE];
				if (!hwdata_i[`BIT_WRITE_ABORT])
					write_abort_reg <= 1'b0;
				if (write_start) begin
					// only a full unlock with write enable and config space clear starts a write
					write_trigger_reg <= 1'b1;
					state_reg <= ST_WN1;
					nop_reg <= 1'b1;
					op_erase_reg <= hwdata_i[`BIT_ROW_ERASE];
					op_prog_reg <= ~hwdata_i[`BIT_ROW_ERASE] & ~hwdata_i[`BIT_LATCH_ONLY];
					load_req_reg <= ~hwdata_i[`BIT_ROW_ERASE];
				end else if (read_start) begin
					read_trigger_reg <= 1'b1;
					state_reg <= ST_RD1;
				end
			end
			default: ;
			endcase
		end
		// sequencer
		case (state_reg)
		ST_IDLE: ;
		ST_RD1: begin
			state_reg <= ST_RD2;
			nop_reg <= 1'b1;
			flash_rd_reg <= ~config_space_reg;
		end
		ST_RD2: begin
			state_reg <= ST_IDLE;
			nop_reg <= 1'b0;
			flash_rd_reg <= 1'b0;
			read_trigger_reg <= 1'b0;
			data_reg <= config_space_reg ? `RST_DATA : flash_rdata_i;
		end
		ST_WN1: state_reg <= ST_WN2;
		ST_WN2: begin
			nop_reg <= 1'b0;
			if (op_erase_reg || op_prog_reg) begin
				state_reg <= ST_BUSY;
				stall_reg <= 1'b1;
				cnt_reg <= {CNT_W{1'b0}};
				flash_erase_reg <= op_erase_reg;
				flash_prog_reg <= op_prog_reg;
			end else begin
				state_reg <= ST_IDLE;
				write_trigger_reg <= 1'b0;
			end
		end
		ST_BUSY: begin
			if (cnt_reg == OP_LAST) begin
				state_reg <= ST_IDLE;
				stall_reg <= 1'b0;
				flash_erase_reg <= 1'b0;
				flash_prog_reg <= 1'b0;
				write_trigger_reg <= 1'b0;
				op_erase_reg <= 1'b0;
				op_prog_reg <= 1'b0;
				blank_req_reg <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
		default: state_reg <= ST_IDLE;
		endcase
	end
end

endmodule // flash_self_program_sequencer

// file: dv/flash_seq_checker.sv
`timescale 1ns/1ps
module flash_seq_checker #(parameter LATCHES = 32, parameter OP_CYCLES = 20) (
	// clock and resets
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire core_reset_i,
	// bus
	input wire hsel_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire hready_i,
	input wire hreadyout_o,
	// flash and core
	input wire [14:0] flash_addr_o,
	input wire flash_rd_o,
	input wire flash_erase_o,
	input wire flash_prog_o,
	input wire [LATCHES*14-1:0] flash_row_data_o,
	input wire cpu_nop_force_o,
	input wire cpu_stall_o
);
	reg [15:0] stall_cnt;
	wire take = hsel_i && htrans_i[1] && hready_i;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			stall_cnt <= 16'h0000;
		else
			stall_cnt <= cpu_stall_o ? stall_cnt + 16'h0001 : 16'h0000;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i || core_reset_i);
	a_write_wait: assert property (take && hwrite_i |=> !hreadyout_o ##1 hreadyout_o) else $error("write wait");
	a_read_wait: assert property (take && !hwrite_i |=> hreadyout_o) else $error("read wait");
	a_read_slot: assert property (flash_rd_o |-> cpu_nop_force_o ##1 !flash_rd_o) else $error("read slot");
	a_nop_pair: assert property ($rose(cpu_nop_force_o) && !flash_rd_o && !$past(hreadyout_o) |->
		cpu_nop_force_o ##1 cpu_nop_force_o ##1 !cpu_nop_force_o) else $error("nop pair");
	a_stall_after: assert property ($rose(cpu_stall_o) |-> $past(cpu_nop_force_o) && !cpu_nop_force_o)
		else $error("stall start");
	a_stall_len: assert property ($fell(cpu_stall_o) && !$past(core_reset_i) |-> stall_cnt == OP_CYCLES)
		else $error("stall length");
	a_op_stalls: assert property (flash_erase_o || flash_prog_o |-> cpu_stall_o) else $error("op no stall");
	a_latch_blank: assert property ($fell(flash_prog_o) |-> ##[0:2] flash_row_data_o == {LATCHES{14'h3fff}})
		else $error("latches not blank");
	a_row_frozen: assert property (flash_erase_o && $past(flash_erase_o) |-> $stable(flash_addr_o))
		else $error("row moved");
	a_one_op: assert property (!(flash_erase_o && flash_prog_o)) else $error("erase with program");
endmodule // flash_seq_checker
bind flash_self_program_sequencer flash_seq_checker #(.LATCHES(LATCHES), .OP_CYCLES(OP_CYCLES)) chk_i (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .core_reset_i(core_reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .flash_addr_o(flash_addr_o),
	.flash_rd_o(flash_rd_o), .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o),
	.flash_row_data_o(flash_row_data_o), .cpu_nop_force_o(cpu_nop_force_o), .cpu_stall_o(cpu_stall_o));

// file: dv/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
	// strobe side
	input wire sys_clk_i,
	input wire flash_rd_i,
	input wire [14:0] flash_addr_i,
	// word back
	output wire [13:0] flash_rdata_o
);
	reg junk_reg = 1'b0;
	// outside the strobe the word toggles so a late sample shows up
	always @(posedge sys_clk_i) begin
		junk_reg <= ~junk_reg;
	end
	assign flash_rdata_o = flash_rd_i ? (flash_addr_i[13:0] ^ 14'h1555) : {7{junk_reg, ~junk_reg}};
endmodule // flash_array_model

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic sys_clk_i = 0, rst_n_i = 0, core_reset_i = 0, hsel_i = 0, hwrite_i = 0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, q;
	wire [31:0] hrdata_o;
	wire hreadyout_o, hresp_o, flash_rd_o, flash_erase_o, flash_prog_o, cpu_nop_force_o, cpu_stall_o;
	wire [14:0] flash_addr_o;
	wire [13:0] flash_rdata_i;
	wire [447:0] flash_row_data_o;
	int failures = 0, checked = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	flash_self_program_sequencer #(.OP_CYCLES(20)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.core_reset_i(core_reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .flash_addr_o(flash_addr_o), .flash_rd_o(flash_rd_o),
		.flash_rdata_i(flash_rdata_i), .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o),
		.flash_row_data_o(flash_row_data_o), .cpu_nop_force_o(cpu_nop_force_o), .cpu_stall_o(cpu_stall_o));
	flash_array_model mem (.sys_clk_i(sys_clk_i), .flash_rd_i(flash_rd_o), .flash_addr_i(flash_addr_o),
		.flash_rdata_o(flash_rdata_i));
	task wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task give_up;
		failures++;
		$display("[ERR] %0t wait ran out", $time);
		wrap_up();
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel_i <= 1'b1; htrans_i <= 2'h2; haddr_i <= {24'h0, a}; hwrite_i <= w;
		do begin @(posedge sys_clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 20);
		if (n >= 20) give_up();
		hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= d;
		do begin @(posedge sys_clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 40);
		if (n >= 40) give_up();
		q = hrdata_o;
	endtask
	// k: 0 idle, 1 program running, 2 erase running
	task wait_for(input int k);
		int n;
		n = 0;
		do begin @(posedge sys_clk_i); n++; end
		while (!(k == 0 ? (cpu_stall_o === 1'b0 && cpu_nop_force_o === 1'b0) :
			k == 1 ? flash_prog_o === 1'b1 : flash_erase_o === 1'b1) && n < 100);
		if (n >= 100) give_up();
	endtask
	task set_ad(input logic [14:0] a);
		bus(1, 8'h00, {25'h0, a[14:8]});
		bus(1, 8'h04, {24'h0, a[7:0]});
	endtask
	task set_dt(input logic [13:0] d);
		bus(1, 8'h0c, {26'h0, d[13:8]});
		bus(1, 8'h08, {24'h0, d[7:0]});
	endtask
	task unlock(input logic [31:0] ctl);
		bus(1, 8'h14, 32'h55);
		bus(1, 8'h14, 32'haa);
		bus(1, 8'h10, ctl);
	endtask
	function automatic logic [13:0] lat(input int i);
		lat = flash_row_data_o[14*i +: 14];
	endfunction
	task t_reset;
		bus(0, 8'h10, 0); chk(q, 0);
		bus(0, 8'h00, 0); chk(q, 0);
		bus(1, 8'h14, 32'h55); bus(0, 8'h14, 0); chk(q, 0);
		bus(0, 8'h20, 0); chk(q, 0);
		chk(hresp_o, 0);
		chk(lat(0), 14'h3fff);
		$display("t_reset done");
	endtask
	task t_read;
		set_ad(15'h1234);
		bus(1, 8'h10, 32'h01);
		repeat (2) @(posedge sys_clk_i);
		chk(flash_addr_o, 15'h1234);
		bus(0, 8'h08, 0); chk(q, 32'h61);
		bus(0, 8'h0c, 0); chk(q, 32'h07);
		bus(0, 8'h10, 0); chk(q[0], 0);
		// config space read clears the data pair
		bus(1, 8'h10, 32'h41); repeat (2) @(posedge sys_clk_i);
		bus(0, 8'h08, 0); chk(q, 0);
		bus(0, 8'h10, 0); chk(q[0], 0);
		$display("t_read done");
	endtask
	task t_latch;
		bus(1, 8'h10, 32'h24);
		set_ad(15'h0123); set_dt(14'h2abc);
		bus(1, 8'h14, 32'h55); bus(1, 8'h08, 32'hbc); bus(1, 8'h14, 32'haa); bus(1, 8'h10, 32'h26);
		repeat (3) @(posedge sys_clk_i);
		chk(lat(3), 14'h3fff);
		unlock(32'h22); bus(0, 8'h10, 0); chk(q[1], 0);
		chk(lat(3), 14'h3fff);
		unlock(32'h26);
		chk(cpu_nop_force_o, 1);
		repeat (4) begin @(posedge sys_clk_i); chk(cpu_stall_o, 0); end
		chk(lat(3), 14'h2abc);
		chk(lat(2), 14'h3fff);
		bus(0, 8'h10, 0); chk(q[1], 0);
		$display("t_latch done");
	endtask
	task t_prog;
		set_ad(15'h0124); set_dt(14'h1111);
		unlock(32'h06); wait_for(1);
		chk(lat(3), 14'h2abc);
		chk(lat(4), 14'h1111);
		chk(lat(31), 14'h3fff);
		chk(flash_addr_o[14:5], 10'h009);
		chk(flash_erase_o, 0);
		wait_for(0); @(posedge sys_clk_i);
		chk(lat(3), 14'h3fff);
		bus(0, 8'h10, 0); chk(q[1], 0);
		$display("t_prog done");
	endtask
	task t_erase;
		set_ad(15'h0137); unlock(32'h16); wait_for(2);
		chk(flash_addr_o[14:5], 10'h009);
		chk(cpu_stall_o, 1);
		chk(flash_prog_o, 0);
		wait_for(0);
		unlock(32'h16); wait_for(2);
		core_reset_i <= 1'b1; @(posedge sys_clk_i);
		core_reset_i <= 1'b0; @(posedge sys_clk_i);
		bus(0, 8'h10, 0); chk(q[3], 1);
		chk(flash_erase_o, 0);
		bus(1, 8'h10, 0); bus(0, 8'h10, 0); chk(q[3], 0);
		$display("t_erase done");
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		t_reset(); t_read(); t_latch(); t_prog(); t_erase();
		wrap_up();
	end
endmodule // testbench
